// ==== logic/nomc_defines.vh ====
// constants for the nfc operation mode configuration block
`ifndef NOMC_DEFINES_VH
`define NOMC_DEFINES_VH
`define NOMC_ADDR_W        8
`define NOMC_OFS_OPCTL     8'h02
`define NOMC_OFS_MODE      8'h03
`define NOMC_OFS_RATE      8'h04
`define NOMC_OFS_CTRL      8'h10
`define NOMC_OFS_STAT      8'h11
`define NOMC_RST_OPCTL     8'h00
`define NOMC_RST_MODE      8'h08
`define NOMC_RST_RATE      8'h00
`define NOMC_RST_CTRL      8'h00
`define NOMC_RATE_MASK     8'h33
`define NOMC_BIT_EN        7
`define NOMC_BIT_RXEN      6
`define NOMC_BIT_RXCHN     5
`define NOMC_BIT_RXMAN     4
`define NOMC_BIT_TXEN      3
`define NOMC_BIT_WAKE      2
`define NOMC_BIT_TARG      7
`define NOMC_BIT_AM        2
`define NOMC_BIT_CHSEL     0
`define NOMC_BIT_PTRES     1
`define NOMC_BIT_TFF       2
`define NOMC_FD_OFF        2'h0
`define NOMC_FD_CA         2'h1
`define NOMC_FD_PEER       2'h2
`define NOMC_FD_AUTO       2'h3
`define NOMC_AR_OFF        2'h0
`define NOMC_AR_ANY        2'h1
`define NOMC_AR_PEEROFF    2'h2
`define NOMC_OM_I_P2P      4'h0
`define NOMC_OM_I_A        4'h1
`define NOMC_OM_I_B        4'h2
`define NOMC_OM_I_F        4'h3
`define NOMC_OM_I_T1       4'h4
`define NOMC_OM_I_SUBC     4'he
`define NOMC_OM_I_BPSK     4'hf
`define NOMC_OM_T_A        4'h1
`define NOMC_OM_T_F        4'h4
`define NOMC_OM_T_P2P      4'h7
`define NOMC_DIV_128       3'h0
`define NOMC_DIV_64        3'h1
`define NOMC_DIV_32        3'h2
`define NOMC_DIV_16        3'h3
`define NOMC_DIV_NONE      3'h4
`define NOMC_PROT_NONE     4'h0
`define NOMC_PROT_I_P2P    4'h1
`define NOMC_PROT_I_A      4'h2
`define NOMC_PROT_I_B      4'h3
`define NOMC_PROT_I_F      4'h4
`define NOMC_PROT_I_T1     4'h5
`define NOMC_PROT_I_SUBC   4'h6
`define NOMC_PROT_I_BPSK   4'h7
`define NOMC_PROT_T_A      4'h8
`define NOMC_PROT_T_F      4'h9
`define NOMC_PROT_T_P2P    4'ha
`define NOMC_PROT_T_BRD    4'hb
`endif

// ==== logic/nomc_top.v ====
// nfc operation mode configuration register bank and decode
//
// Strobed register access was chosen for this implementation.
`timescale 1ns/100ps
`include "nomc_defines.vh"

// What this block does
// [RULE1] control bit 7 enables oscillator and regulators, ready state
// [RULE2] control bit 6 enables the receiver
// [RULE3] control bit 5: zero both channels, one single channel by channel_choice
// [RULE4] both channels: bit 4 zero automatic, one manual by channel_choice
// [RULE5] bit 3 enables transmit; set by field-on, cleared after active p2p transmit
// [RULE6] control bit 2 enables wake-up mode per wake-up timer settings
// [RULE7] detector field: off, collision threshold, peer threshold, automatic
// [RULE8] detector nonzero with other control bits zero gives low-power initial state
// [RULE9] control register defaults only at power-up, not on other resets
// [RULE10] mode bit 7 selects initiator or target; mode code decode depends on it
// [RULE11] mode bit 2 selects on-off keying or amplitude modulation
// [RULE12] auto response field: off, after any reception, after peer field-off, reserved
// [RULE13] mode register writes only accepted while crystal clock is stable
// [RULE14] initiator codes decode to protocols; unsupported disables transmit and receive
// [RULE15] target codes: type A, type F passive, active p2p; others not allowed
// [RULE16] target code msb: rate detection, bit 2 type F, bit 0 type A
// [RULE17] software must not set transport frame format in rate detection
// [RULE18] passive target and rate detection use passive target resistance
// [RULE19] rate register bits 5:4 transmit rate, bits 7:6 reserved
// [RULE20] rate register bits 1:0 receive rate, bits 3:2 reserved
// [RULE21] rate codes divide carrier by 128,64,32,16; unsupported disables tx and rx
// [RULE22] reserved bits read zero and ignore writes
module nomc_top (
   // clock and resets
   input  wire       mclk,
   input  wire       rstn,
   input  wire       por_n,
   // register port
   input  wire [7:0] reg_addr,
   input  wire [7:0] reg_wdata,
   input  wire       reg_wr,
   input  wire       reg_rd,
   output reg  [7:0] reg_rdata,
   // device events, asynchronous
   input  wire       osc_stable,
   input  wire       field_on_cmd,
   input  wire       tx_done,
   // decoded controls
   output reg        osc_reg_enable,
   output reg        rx_enable,
   output reg        rx_am_enable,
   output reg        rx_pm_enable,
   output reg        rx_auto_select,
   output reg        tx_enable,
   output reg        wakeup_mode_enable,
   output reg  [1:0] field_detector_mode,
   output reg        low_power_initial,
   output reg        target_role,
   output reg  [3:0] protocol_mode,
   output reg        fd_rate_detect_en,
   output reg        a_rate_detect_en,
   output reg        am_modulation_select,
   output reg  [1:0] auto_response_mode,
   output reg        use_passive_target_res,
   output reg        transport_frame_conflict,
   output reg  [2:0] tx_rate_div,
   output reg  [2:0] rx_rate_div
);

////////////////////////////////////////////////////////////////////////////////
// input synchronisers
reg  [2:0] sync1_ff;
reg  [2:0] sync2_ff;
reg  [1:0] evt_prev_ff;
reg        por_s1_ff;
reg        por_s2_ff;
wire       osc_ok;
wire       field_on_pulse;
wire       tx_done_pulse;

always @(posedge mclk) begin
   sync1_ff    <= {tx_done, field_on_cmd, osc_stable};
   sync2_ff    <= sync1_ff;
   evt_prev_ff <= sync2_ff[2:1];
   por_s1_ff   <= por_n;
   por_s2_ff   <= por_s1_ff;
end

assign osc_ok         = sync2_ff[0];
assign field_on_pulse = sync2_ff[1] & ~evt_prev_ff[0];
assign tx_done_pulse  = sync2_ff[2] & ~evt_prev_ff[1];

////////////////////////////////////////////////////////////////////////////////
// registers
reg  [7:0] opctl_ff;
reg  [7:0] mode_ff;
reg  [7:0] rate_ff;
reg  [7:0] ctrl_ff;
reg  [7:0] nxt_opctl;
reg  [3:0] nxt_prot;
reg        nxt_txrx_ok;
reg  [2:0] nxt_tx_div;
reg  [2:0] nxt_rx_div;
wire       wr_opctl;
wire       wr_mode;
wire       wr_rate;
wire       wr_ctrl;
wire       active_p2p;
wire [3:0] om_code;

assign wr_opctl = reg_wr & (reg_addr == `NOMC_OFS_OPCTL);
assign wr_mode  = reg_wr & (reg_addr == `NOMC_OFS_MODE) & osc_ok;   // [RULE13]
assign wr_rate  = reg_wr & (reg_addr == `NOMC_OFS_RATE);
assign wr_ctrl  = reg_wr & (reg_addr == `NOMC_OFS_CTRL);
assign om_code  = mode_ff[6:3];
assign active_p2p = (!mode_ff[`NOMC_BIT_TARG] && om_code == `NOMC_OM_I_P2P) ||
                    (mode_ff[`NOMC_BIT_TARG] && om_code == `NOMC_OM_T_P2P);

// hardware set of tx enable wins over software write and auto clear
always @* begin
   nxt_opctl = opctl_ff;
   if (wr_opctl) begin
      nxt_opctl = reg_wdata;
   end
   if (tx_done_pulse && active_p2p) begin
      nxt_opctl[`NOMC_BIT_TXEN] = 1'b0;           // [RULE5]
   end
   if (field_on_pulse) begin
      nxt_opctl[`NOMC_BIT_TXEN] = 1'b1;           // [RULE5]
   end
end

// control register restored by power-up only
always @(posedge mclk) begin
   if (!por_s2_ff) begin
      opctl_ff <= `NOMC_RST_OPCTL;                // [RULE9]
   end else begin
      opctl_ff <= nxt_opctl;
   end
end

always @(posedge mclk) begin
   if (!rstn) begin
      mode_ff <= `NOMC_RST_MODE;
      rate_ff <= `NOMC_RST_RATE;
      ctrl_ff <= `NOMC_RST_CTRL;
   end else begin
      if (wr_mode) begin
         mode_ff <= reg_wdata;
      end
      if (wr_rate) begin
         rate_ff <= reg_wdata & `NOMC_RATE_MASK;  // [RULE19] [RULE20] [RULE22]
      end
      if (wr_ctrl) begin
         ctrl_ff <= {5'h00, reg_wdata[2:0]};      // [RULE22]
      end
   end
end

////////////////////////////////////////////////////////////////////////////////
// read port, data one cycle after strobe
always @(posedge mclk) begin
   if (!rstn) begin
      reg_rdata <= 8'h00;
   end else if (reg_rd) begin
      if (reg_addr == `NOMC_OFS_OPCTL) begin
         reg_rdata <= opctl_ff;
      end else if (reg_addr == `NOMC_OFS_MODE) begin
         reg_rdata <= mode_ff;
      end else if (reg_addr == `NOMC_OFS_RATE) begin
         reg_rdata <= rate_ff;
      end else if (reg_addr == `NOMC_OFS_CTRL) begin
         reg_rdata <= ctrl_ff;
      end else if (reg_addr == `NOMC_OFS_STAT) begin
         reg_rdata <= {5'h00, transport_frame_conflict, low_power_initial, osc_ok};
      end else begin
         reg_rdata <= 8'h00;
      end
   end else begin
      reg_rdata <= 8'h00;
   end
end

////////////////////////////////////////////////////////////////////////////////
// mode and rate decode
always @* begin
   nxt_prot    = `NOMC_PROT_NONE;
   nxt_txrx_ok = 1'b1;
   if (!mode_ff[`NOMC_BIT_TARG]) begin
      case (om_code)                                  // [RULE10] [RULE14]
         `NOMC_OM_I_P2P:  nxt_prot = `NOMC_PROT_I_P2P;
         `NOMC_OM_I_A:    nxt_prot = `NOMC_PROT_I_A;
         `NOMC_OM_I_B:    nxt_prot = `NOMC_PROT_I_B;
         `NOMC_OM_I_F:    nxt_prot = `NOMC_PROT_I_F;
         `NOMC_OM_I_T1:   nxt_prot = `NOMC_PROT_I_T1;
         `NOMC_OM_I_SUBC: nxt_prot = `NOMC_PROT_I_SUBC;
         `NOMC_OM_I_BPSK: nxt_prot = `NOMC_PROT_I_BPSK;
         default:         nxt_txrx_ok = 1'b0;
      endcase
   end else if (om_code[3]) begin
      nxt_prot = `NOMC_PROT_T_BRD;                     // [RULE16]
   end else begin
      case (om_code)                                  // [RULE15]
         `NOMC_OM_T_A:   nxt_prot = `NOMC_PROT_T_A;
         `NOMC_OM_T_F:   nxt_prot = `NOMC_PROT_T_F;
         `NOMC_OM_T_P2P: nxt_prot = `NOMC_PROT_T_P2P;
         default:        nxt_txrx_ok = 1'b0;
      endcase
   end
   nxt_tx_div = {1'b0, rate_ff[5:4]};                 // [RULE21]
   nxt_rx_div = {1'b0, rate_ff[1:0]};                 // [RULE21]
   if (!nxt_txrx_ok) begin
      nxt_tx_div = `NOMC_DIV_NONE;
      nxt_rx_div = `NOMC_DIV_NONE;
   end
end

////////////////////////////////////////////////////////////////////////////////
// registered outputs
always @(posedge mclk) begin
   if (!rstn) begin
      osc_reg_enable           <= 1'b0;
      rx_enable                <= 1'b0;
      rx_am_enable             <= 1'b0;
      rx_pm_enable             <= 1'b0;
      rx_auto_select           <= 1'b0;
      tx_enable                <= 1'b0;
      wakeup_mode_enable       <= 1'b0;
      field_detector_mode      <= `NOMC_FD_OFF;
      low_power_initial        <= 1'b0;
      target_role              <= 1'b0;
      protocol_mode            <= `NOMC_PROT_NONE;
      fd_rate_detect_en        <= 1'b0;
      a_rate_detect_en         <= 1'b0;
      am_modulation_select     <= 1'b0;
      auto_response_mode       <= `NOMC_AR_OFF;
      use_passive_target_res   <= 1'b0;
      transport_frame_conflict <= 1'b0;
      tx_rate_div              <= `NOMC_DIV_NONE;
      rx_rate_div              <= `NOMC_DIV_NONE;
   end else begin
      osc_reg_enable      <= opctl_ff[`NOMC_BIT_EN];                              // [RULE1]
      rx_enable           <= opctl_ff[`NOMC_BIT_RXEN] & nxt_txrx_ok;              // [RULE2] [RULE14]
      rx_am_enable        <= opctl_ff[`NOMC_BIT_RXEN] &
                             (~opctl_ff[`NOMC_BIT_RXCHN] | ~ctrl_ff[`NOMC_BIT_CHSEL]); // [RULE3]
      rx_pm_enable        <= opctl_ff[`NOMC_BIT_RXEN] &
                             (~opctl_ff[`NOMC_BIT_RXCHN] | ctrl_ff[`NOMC_BIT_CHSEL]);  // [RULE3]
      rx_auto_select      <= ~opctl_ff[`NOMC_BIT_RXCHN] & ~opctl_ff[`NOMC_BIT_RXMAN]; // [RULE4]
      tx_enable           <= opctl_ff[`NOMC_BIT_TXEN] & nxt_txrx_ok;              // [RULE5] [RULE14]
      wakeup_mode_enable  <= opctl_ff[`NOMC_BIT_WAKE];                            // [RULE6]
      field_detector_mode <= opctl_ff[1:0];                                       // [RULE7]
      low_power_initial   <= (opctl_ff[1:0] != `NOMC_FD_OFF) && (opctl_ff[7:2] == 6'h00); // [RULE8]
      target_role         <= mode_ff[`NOMC_BIT_TARG];                             // [RULE10]
      protocol_mode       <= nxt_prot;
      fd_rate_detect_en   <= (nxt_prot == `NOMC_PROT_T_BRD) & om_code[2];         // [RULE16]
      a_rate_detect_en    <= (nxt_prot == `NOMC_PROT_T_BRD) & om_code[0];         // [RULE16]
      am_modulation_select <= mode_ff[`NOMC_BIT_AM];                              // [RULE11]
      if (mode_ff[1:0] == `NOMC_FD_AUTO) begin
         auto_response_mode <= `NOMC_AR_OFF;                                      // [RULE12]
      end else begin
         auto_response_mode <= mode_ff[1:0];                                      // [RULE12]
      end
      use_passive_target_res <= ctrl_ff[`NOMC_BIT_PTRES] &
                                ((nxt_prot == `NOMC_PROT_T_A) || (nxt_prot == `NOMC_PROT_T_F) ||
                                 (nxt_prot == `NOMC_PROT_T_BRD));                 // [RULE18]
      transport_frame_conflict <= ctrl_ff[`NOMC_BIT_TFF] & (nxt_prot == `NOMC_PROT_T_BRD); // [RULE17]
      tx_rate_div         <= nxt_tx_div;                                          // [RULE21]
      rx_rate_div         <= nxt_rx_div;                                          // [RULE21]
   end
end

endmodule

// ==== testbench/nomc_top_assertions.sv ====
// concurrent checks on the nfc configuration block ports
`timescale 1ns/100ps
module nomc_checker (
   // clock, reset and register port
   input wire       mclk,
   input wire       rstn,
   input wire [7:0] reg_addr,
   input wire [7:0] reg_wdata,
   input wire       reg_wr,
   input wire       reg_rd,
   input wire [7:0] reg_rdata,
   // decoded controls
   input wire       osc_reg_enable,
   input wire       rx_enable,
   input wire       rx_am_enable,
   input wire       rx_pm_enable,
   input wire       rx_auto_select,
   input wire       wakeup_mode_enable,
   input wire [1:0] field_detector_mode,
   input wire       low_power_initial,
   input wire       target_role,
   input wire [3:0] protocol_mode,
   input wire       a_rate_detect_en,
   input wire [1:0] auto_response_mode,
   input wire       use_passive_target_res,
   input wire [2:0] tx_rate_div
);
   default clocking @(posedge mclk); endclocking
   default disable iff (!rstn);
   sequence opw;
      reg_wr && reg_addr == 8'h02 ##1 !(reg_wr && reg_addr == 8'h02);
   endsequence
   osc_follow_a: assert property (opw |=> osc_reg_enable == $past(reg_wdata[7], 2))
      else $error("oscillator enable mismatch");
   wake_follow_a: assert property (opw |=> wakeup_mode_enable == $past(reg_wdata[2], 2))
      else $error("wake-up enable mismatch");
   fd_follow_a: assert property (opw |=> field_detector_mode == $past(reg_wdata[1:0], 2))
      else $error("field detector mode mismatch");
   auto_both_a: assert property (rx_auto_select && rx_enable |-> rx_am_enable && rx_pm_enable)
      else $error("auto select without both channels");
   low_power_a: assert property (low_power_initial |-> field_detector_mode != 2'h0
      && !osc_reg_enable && !wakeup_mode_enable)
      else $error("low power state with other bits set");
   rx_gate_a: assert property (rx_enable |-> protocol_mode != 4'h0)
      else $error("receiver on in unsupported mode");
   div_off_a: assert property ((protocol_mode == 4'h0) == (tx_rate_div == 3'h4))
      else $error("rate divider and mode disagree");
   ar_resv_a: assert property (auto_response_mode != 2'h3)
      else $error("reserved auto response code active");
   brd_only_a: assert property (a_rate_detect_en |-> target_role && protocol_mode == 4'hb)
      else $error("rate detect outside detection mode");
   ptres_targ_a: assert property (use_passive_target_res |-> target_role)
      else $error("passive resistance in initiator role");
   rate_resv_a: assert property (reg_rd && reg_addr == 8'h04 |=> (reg_rdata & 8'hcc) == 8'h00)
      else $error("reserved rate bits read nonzero");
   cover property (opw);
   cover property (a_rate_detect_en);
   cover property (low_power_initial);
endmodule
bind nomc_top nomc_checker i_nomc_checker (.mclk, .rstn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
   .reg_rdata, .osc_reg_enable, .rx_enable, .rx_am_enable, .rx_pm_enable, .rx_auto_select,
   .wakeup_mode_enable, .field_detector_mode, .low_power_initial, .target_role, .protocol_mode,
   .a_rate_detect_en, .auto_response_mode, .use_passive_target_res, .tx_rate_div);

// ==== testbench/nomc_top_tb.sv ====
// self-checking bench for the nfc configuration block
`timescale 1ns/100ps
module nomc_top_tb;
   reg        mclk = 1'b0;
   reg        rstn = 1'b0;
   reg        por_n = 1'b0;
   reg  [7:0] reg_addr = 8'h00;
   reg  [7:0] reg_wdata = 8'h00;
   reg        reg_wr = 1'b0;
   reg        reg_rd = 1'b0;
   reg        osc_stable = 1'b0;
   reg        field_on_cmd = 1'b0;
   reg        tx_done = 1'b0;
   wire [7:0] reg_rdata;
   wire       osc_reg_enable, rx_enable, rx_am_enable, rx_pm_enable, rx_auto_select;
   wire       tx_enable, wakeup_mode_enable, low_power_initial, target_role;
   wire       fd_rate_detect_en, a_rate_detect_en, am_modulation_select;
   wire       use_passive_target_res, transport_frame_conflict;
   wire [1:0] field_detector_mode, auto_response_mode;
   wire [3:0] protocol_mode;
   wire [2:0] tx_rate_div, rx_rate_div;
   int        errors = 0;
   int        total_checks = 0;
   reg  [7:0] i;
   reg  [7:0] md [13] = '{8'h00, 8'h08, 8'h10, 8'h18, 8'h20, 8'h70, 8'h78, 8'h88, 8'ha0, 8'hb8,
                          8'hc0, 8'h28, 8'h80};
   reg  [3:0] pm [13] = '{4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9, 4'ha, 4'hb, 4'h0, 4'h0};
   nomc_top i_nomc_top (.mclk, .rstn, .por_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .osc_stable, .field_on_cmd, .tx_done, .osc_reg_enable, .rx_enable, .rx_am_enable, .rx_pm_enable,
      .rx_auto_select, .tx_enable, .wakeup_mode_enable, .field_detector_mode, .low_power_initial,
      .target_role, .protocol_mode, .fd_rate_detect_en, .a_rate_detect_en, .am_modulation_select,
      .auto_response_mode, .use_passive_target_res, .transport_frame_conflict, .tx_rate_div, .rx_rate_div);
   always #10 mclk = ~mclk;
   ////////////////////////////////////////////////////////////////////////
   task give_verdict;
      $display("checks %0d errors %0d", total_checks, errors);
      if (errors == 0 && total_checks > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task chk(input [7:0] g, input [7:0] e);
      total_checks++;
      if (g !== e) begin
         errors++;
         $display("[ERR] t=%0t got %h exp %h", $time, g, e);
      end
   endtask
   // write, then let the decoded outputs settle
   task wr(input [7:0] a, input [7:0] d);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge mclk);
      reg_wr <= 1'b0;
      repeat (2) @(posedge mclk);
   endtask
   task rd(input [7:0] a, input [7:0] e);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge mclk);
      reg_rd <= 1'b0;
      @(posedge mclk);
      chk(reg_rdata, e);
   endtask
   ////////////////////////////////////////////////////////////////////////
   task t_reset;
      rd(8'h02, 8'h00);
      rd(8'h03, 8'h08);
      rd(8'h04, 8'h00);
      chk(protocol_mode, 4'h2);
   endtask
   task t_opctl;
      wr(8'h02, 8'hc0);
      chk({osc_reg_enable, rx_enable}, 2'h3);
      chk({rx_am_enable, rx_pm_enable, rx_auto_select}, 3'h7);
      wr(8'h02, 8'h70);
      chk({osc_reg_enable, rx_enable, rx_am_enable, rx_pm_enable, rx_auto_select}, 5'h0c);
      wr(8'h02, 8'h50);
      chk({rx_am_enable, rx_pm_enable, rx_auto_select}, 3'h6);
      wr(8'h10, 8'h01);
      wr(8'h02, 8'h60);
      chk({rx_am_enable, rx_pm_enable}, 2'h1);
   endtask
   task t_fd;
      for (i = 0; i < 4; i++) begin
         wr(8'h02, i);
         chk({field_detector_mode, low_power_initial}, {i[1:0], i != 0});
      end
      wr(8'h02, 8'h05);
      chk({wakeup_mode_enable, low_power_initial}, 2'h2);
   endtask
   task t_rst;
      wr(8'h02, 8'h84);
      rstn <= 1'b0;
      @(posedge mclk);
      rstn <= 1'b1;
      @(posedge mclk);
      rd(8'h02, 8'h84);
      rd(8'h03, 8'h08);
   endtask
   task t_mode;
      osc_stable <= 1'b0;
      repeat (4) @(posedge mclk);
      wr(8'h03, 8'h80);
      rd(8'h03, 8'h08);
      osc_stable <= 1'b1;
      repeat (4) @(posedge mclk);
      wr(8'h02, 8'hc8);
      for (i = 0; i < 13; i++) begin
         wr(8'h03, md[i]);
         chk({target_role, protocol_mode}, {md[i][7], pm[i]});
         chk({rx_enable, tx_enable}, {2{pm[i] != 4'h0}});
         chk(tx_rate_div, (pm[i] == 4'h0) ? 3'h4 : 3'h0);
      end
      wr(8'h03, 8'h8f);
      chk({am_modulation_select, auto_response_mode}, 3'h4);
      wr(8'h03, 8'h0d);
      chk({am_modulation_select, auto_response_mode}, 3'h5);
      wr(8'h03, 8'h0a);
      chk({am_modulation_select, auto_response_mode}, 3'h2);
      wr(8'h10, 8'h06);
      wr(8'h03, 8'he8);
      chk({fd_rate_detect_en, a_rate_detect_en, use_passive_target_res, transport_frame_conflict}, 4'hf);
      rd(8'h11, 8'h05);
      wr(8'h03, 8'hc0);
      chk({fd_rate_detect_en, a_rate_detect_en, use_passive_target_res}, 3'h1);
      rd(8'h10, 8'h06);
   endtask
   task t_rate;
      wr(8'h03, 8'h08);
      wr(8'h04, 8'hff);
      rd(8'h04, 8'h33);
      for (i = 0; i < 4; i++) begin
         wr(8'h04, {2'h0, i[1:0], 2'h0, ~i[1:0]});
         chk({tx_rate_div, rx_rate_div}, {i[2:0], 3'h3 - i[2:0]});
      end
      rd(8'h20, 8'h00);
   endtask
   task t_tx;
      wr(8'h03, 8'h00);
      wr(8'h02, 8'h88);
      chk(tx_enable, 1'b1);
      tx_done <= 1'b1;
      repeat (6) @(posedge mclk);
      tx_done <= 1'b0;
      rd(8'h02, 8'h80);
      field_on_cmd <= 1'b1;
      repeat (6) @(posedge mclk);
      field_on_cmd <= 1'b0;
      rd(8'h02, 8'h88);
   endtask
   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (8) @(posedge mclk);
      rstn <= 1'b1;
      por_n <= 1'b1;
      osc_stable <= 1'b1;
      @(posedge mclk);
      t_reset;
      t_opctl;
      t_fd;
      t_rst;
      t_mode;
      t_rate;
      t_tx;
      give_verdict;
   end
   initial begin
      repeat (5000) @(posedge mclk);
      errors++;
      give_verdict;
   end
endmodule
